// file: hw/adcseq_pkg.sv
// Package of register offsets, field positions, reset values and timing for the sequencer.
package adcseq_pkg;
  // Byte offsets on the APB bus, one aligned word per register.
  localparam logic [7:0] OFF_IRQ_GLOBAL = 8'h00;
  localparam logic [7:0] OFF_FLAGS_ONE = 8'h04;
  localparam logic [7:0] OFF_ENABLES_ONE = 8'h08;
  localparam logic [7:0] OFF_PRIORITY_ONE = 8'h0C;
  localparam logic [7:0] OFF_FLAGS_TWO = 8'h10;
  localparam logic [7:0] OFF_ENABLES_TWO = 8'h14;
  localparam logic [7:0] OFF_PRIORITY_TWO = 8'h18;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h1C;
  localparam logic [7:0] OFF_RESULT_LOW = 8'h20;
  localparam logic [7:0] OFF_CHANNEL_CTRL = 8'h24;
  localparam logic [7:0] OFF_REF_PIN_CFG = 8'h28;
  localparam logic [7:0] OFF_TIMING_FMT = 8'h2C;
  localparam logic [7:0] OFF_DIR_A = 8'h30;
  localparam logic [7:0] OFF_DIR_F = 8'h34;
  localparam logic [7:0] OFF_DIR_H = 8'h38;
  localparam logic [7:0] OFF_COMPARE2_CTRL = 8'h3C;
  // Writable masks; the zero bits are unimplemented and read as zero.
  localparam logic [7:0] MASK_FLAGS_ONE = 8'h7F;
  localparam logic [7:0] MASK_FLAGS_TWO = 8'hCF;
  localparam logic [7:0] MASK_CHANNEL_CTRL = 8'h3F;
  localparam logic [7:0] MASK_REF_PIN_CFG = 8'h3F;
  localparam logic [7:0] MASK_TIMING_FMT = 8'hBF;
  localparam logic [7:0] MASK_COMPARE2 = 8'h0F;
  // Field positions.
  localparam int BIT_CONVERTER_ON = 0;
  localparam int BIT_START_DONE = 1;
  localparam int BIT_IRQ_FLAG = 6;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int BIT_RESULT_JUSTIFY = 7;
  localparam logic [3:0] COMPARE2_SPECIAL_EVENT = 4'hB;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Instruction cycle length in system clocks for the rc clock start delay.
  localparam logic [3:0] INSTR_CYCLE_CLKS = 4'h4;
  // Conversion length in conversion clock periods for a 12-bit result.
  localparam logic [4:0] CONVERT_PERIODS = 5'h0E;
  localparam logic [3:0] RC_CLOCK_SEL_A = 4'h3;
  localparam logic [3:0] RC_CLOCK_SEL_B = 4'h7;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RCWAIT = 5'b00010,
    ST_ACQUIRE = 5'b00100,
    ST_CONVERT = 5'b01000,
    ST_DONE = 5'b10000
  } adcsq_state_e;
endpackage

// file: hw/adcseq_tick_if.sv
// Interface carrying the conversion clock tick between sequencer and divider.
`timescale 1ns/1ps
`default_nettype none
interface adcsq_tick_if;
  logic run;
  logic [2:0] clk_sel;
  logic tick;
  modport ctrl (output run, output clk_sel, input tick);
  modport div (input run, input clk_sel, output tick);
endinterface
`default_nettype wire

// file: hw/adcsq_tick_div.sv
// Conversion clock divider producing one-cycle ticks per conversion clock period.
`timescale 1ns/1ps
`default_nettype none
module adcsq_tick_div #(
  parameter int RC_DIV = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  adcsq_tick_if.div tk
);
  logic [6:0] cnt_q;
  logic [6:0] limit;
  always_comb begin
    case (tk.clk_sel)
      3'h0: limit = 7'h01;
      3'h1: limit = 7'h07;
      3'h2: limit = 7'h1F;
      3'h4: limit = 7'h03;
      3'h5: limit = 7'h0F;
      3'h6: limit = 7'h3F;
      default: limit = 7'(RC_DIV - 1);
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
    end else if (!tk.run || cnt_q >= limit) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
  assign tk.tick = tk.run && (cnt_q >= limit);
endmodule
`default_nettype wire

// file: hw/adcsq_top.sv
// Conversion sequencer top with APB register file, trigger handling and result capture.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - With rc clock selected, wait one instruction cycle before conversion clock starts.
// - Result registers survive every reset except power-on and brown-out.
// - Nonzero acquisition delay is counted in conversion periods before converting.
// - Setting start/done starts conversion; hardware clears it at completion.
// - Compare special event with mode 1011 and converter on sets start/done.
// - Every special event resets the selected timer counter.
// - Converter off ignores the trigger, but timer reset still happens.
// - Unimplemented control and interrupt register bits read as zero.
module adcsq_top
  import adcseq_pkg::*;
#(
  parameter int RC_DIV = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_bor_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic compare2_event,
  input wire logic timer_three_selected,
  input wire logic [11:0] analog_sample,
  output logic [3:0] channel_select,
  output logic sample_hold,
  output logic timer_one_reset,
  output logic timer_three_reset,
  output logic irq_high,
  output logic irq_low
);
  adcsq_tick_if tk ();
  adcsq_state_e state_q;
  logic [7:0] irq_global_q, flags_one_q, enables_one_q, priority_one_q;
  logic [7:0] flags_two_q, enables_two_q, priority_two_q;
  logic [7:0] chan_ctrl_q, ref_pin_q, timing_q, dir_a_q, dir_f_q, dir_h_q, cmp2_q;
  logic [7:0] result_high_q, result_low_q;
  logic [4:0] per_cnt_q;
  logic [3:0] rc_cnt_q;
  logic wr, rd_ok, conv_done, trig_start, sw_start;
  logic [4:0] acq_periods;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;
  assign sw_start = wr && paddr == OFF_CHANNEL_CTRL && pwdata[BIT_START_DONE];
  // Mode gates both the start and the timer reset; the converter enable gates only the start.
  assign trig_start = compare2_event && cmp2_q[3:0] == COMPARE2_SPECIAL_EVENT
                      && chan_ctrl_q[BIT_CONVERTER_ON];
  assign conv_done = state_q == ST_DONE;
  // Timer reset follows every special event regardless of the converter.
  assign timer_one_reset = compare2_event && cmp2_q[3:0] == COMPARE2_SPECIAL_EVENT
                           && !timer_three_selected;
  assign timer_three_reset = compare2_event && cmp2_q[3:0] == COMPARE2_SPECIAL_EVENT
                             && timer_three_selected;

  always_comb begin
    case (timing_q[5:3])
      3'h1: acq_periods = 5'h02;
      3'h2: acq_periods = 5'h04;
      3'h3: acq_periods = 5'h06;
      3'h4: acq_periods = 5'h08;
      3'h5: acq_periods = 5'h0C;
      3'h6: acq_periods = 5'h10;
      3'h7: acq_periods = 5'h14;
      default: acq_periods = 5'h00;
    endcase
  end

  assign tk.run = state_q == ST_ACQUIRE || state_q == ST_CONVERT;
  assign tk.clk_sel = timing_q[2:0];
  adcsq_tick_div #(.RC_DIV(RC_DIV)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      per_cnt_q <= 5'h00;
      rc_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (chan_ctrl_q[BIT_START_DONE]) begin
            rc_cnt_q <= 4'h0;
            per_cnt_q <= 5'h00;
            // Rc clock gets one instruction cycle of grace first.
            if ({1'b0, timing_q[2:0]} == RC_CLOCK_SEL_A
                || {1'b0, timing_q[2:0]} == RC_CLOCK_SEL_B) begin
              state_q <= ST_RCWAIT;
            end else begin
              state_q <= ST_ACQUIRE;
            end
          end
        end
        ST_RCWAIT: begin
          rc_cnt_q <= rc_cnt_q + 4'h1;
          if (rc_cnt_q == INSTR_CYCLE_CLKS - 4'h1) begin
            state_q <= ST_ACQUIRE;
          end
        end
        ST_ACQUIRE: begin
          // Acquisition counted in conversion periods; zero skips it.
          if (acq_periods == 5'h00) begin
            state_q <= ST_CONVERT;
          end else if (tk.tick) begin
            if (per_cnt_q == acq_periods - 5'h01) begin
              per_cnt_q <= 5'h00;
              state_q <= ST_CONVERT;
            end else begin
              per_cnt_q <= per_cnt_q + 5'h01;
            end
          end
        end
        ST_CONVERT: begin
          if (tk.tick) begin
            if (per_cnt_q == CONVERT_PERIODS - 5'h01) begin
              state_q <= ST_DONE;
            end else begin
              per_cnt_q <= per_cnt_q + 5'h01;
            end
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
      // Turning the converter off aborts a conversion in flight.
      if (!chan_ctrl_q[BIT_CONVERTER_ON] && state_q != ST_IDLE) begin
        state_q <= ST_IDLE;
      end
    end
  end
  assign sample_hold = state_q == ST_CONVERT;
  assign channel_select = chan_ctrl_q[5:2];

  // Control register 0; hardware start beats software, but a software start beats the completion clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_ctrl_q <= RESET_BYTE;
    end else begin
      if (wr && paddr == OFF_CHANNEL_CTRL) begin
        chan_ctrl_q <= pwdata[7:0] & MASK_CHANNEL_CTRL;
      end
      if (trig_start) begin
        chan_ctrl_q[BIT_START_DONE] <= 1'b1;
      end else if (conv_done && !sw_start) begin
        chan_ctrl_q[BIT_START_DONE] <= 1'b0;
      end else if (!chan_ctrl_q[BIT_CONVERTER_ON] && !(wr && paddr == OFF_CHANNEL_CTRL)) begin
        chan_ctrl_q[BIT_START_DONE] <= 1'b0;
      end
    end
  end

  // Results only clear on power-on or brown-out; other resets keep them.
  always_ff @(posedge pclk or negedge por_bor_n) begin
    if (!por_bor_n) begin
      result_high_q <= RESET_BYTE;
      result_low_q <= RESET_BYTE;
    end else if (conv_done) begin
      if (timing_q[BIT_RESULT_JUSTIFY]) begin
        result_high_q <= {4'h0, analog_sample[11:8]};
        result_low_q <= analog_sample[7:0];
      end else begin
        result_high_q <= analog_sample[11:4];
        result_low_q <= {analog_sample[3:0], 4'h0};
      end
    end else if (wr && paddr == OFF_RESULT_HIGH) begin
      result_high_q <= pwdata[7:0];
    end else if (wr && paddr == OFF_RESULT_LOW) begin
      result_low_q <= pwdata[7:0];
    end
  end

  // Flag set by completion beats a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_one_q <= RESET_BYTE;
    end else begin
      if (wr && paddr == OFF_FLAGS_ONE) begin
        flags_one_q <= pwdata[7:0] & MASK_FLAGS_ONE;
      end
      if (conv_done) begin
        flags_one_q[BIT_IRQ_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_global_q <= RESET_BYTE;
      enables_one_q <= RESET_BYTE;
      priority_one_q <= RESET_BYTE;
      flags_two_q <= RESET_BYTE;
      enables_two_q <= RESET_BYTE;
      priority_two_q <= RESET_BYTE;
      ref_pin_q <= RESET_BYTE;
      timing_q <= RESET_BYTE;
      dir_a_q <= RESET_BYTE;
      dir_f_q <= RESET_BYTE;
      dir_h_q <= RESET_BYTE;
      cmp2_q <= RESET_BYTE;
    end else if (wr) begin
      case (paddr)
        OFF_IRQ_GLOBAL: irq_global_q <= pwdata[7:0];
        OFF_ENABLES_ONE: enables_one_q <= pwdata[7:0] & MASK_FLAGS_ONE;
        OFF_PRIORITY_ONE: priority_one_q <= pwdata[7:0] & MASK_FLAGS_ONE;
        OFF_FLAGS_TWO: flags_two_q <= pwdata[7:0] & MASK_FLAGS_TWO;
        OFF_ENABLES_TWO: enables_two_q <= pwdata[7:0] & MASK_FLAGS_TWO;
        OFF_PRIORITY_TWO: priority_two_q <= pwdata[7:0] & MASK_FLAGS_TWO;
        OFF_REF_PIN_CFG: ref_pin_q <= pwdata[7:0] & MASK_REF_PIN_CFG;
        OFF_TIMING_FMT: timing_q <= pwdata[7:0] & MASK_TIMING_FMT;
        OFF_DIR_A: dir_a_q <= pwdata[7:0];
        OFF_DIR_F: dir_f_q <= pwdata[7:0];
        OFF_DIR_H: dir_h_q <= pwdata[7:0];
        OFF_COMPARE2_CTRL: cmp2_q <= pwdata[7:0] & MASK_COMPARE2;
        default: cmp2_q <= cmp2_q;
      endcase
    end
  end

  // Request routed by the priority bit, gated by flag, enable and global enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end else begin
      irq_high <= irq_global_q[BIT_GLOBAL_IRQ_ENABLE] && flags_one_q[BIT_IRQ_FLAG]
                  && enables_one_q[BIT_IRQ_FLAG] && priority_one_q[BIT_IRQ_FLAG];
      irq_low <= irq_global_q[BIT_GLOBAL_IRQ_ENABLE] && flags_one_q[BIT_IRQ_FLAG]
                 && enables_one_q[BIT_IRQ_FLAG] && !priority_one_q[BIT_IRQ_FLAG];
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    prdata = 32'h00000000;
    case (paddr)
      OFF_IRQ_GLOBAL: prdata[7:0] = irq_global_q;
      OFF_FLAGS_ONE: prdata[7:0] = flags_one_q;
      OFF_ENABLES_ONE: prdata[7:0] = enables_one_q;
      OFF_PRIORITY_ONE: prdata[7:0] = priority_one_q;
      OFF_FLAGS_TWO: prdata[7:0] = flags_two_q;
      OFF_ENABLES_TWO: prdata[7:0] = enables_two_q;
      OFF_PRIORITY_TWO: prdata[7:0] = priority_two_q;
      OFF_RESULT_HIGH: prdata[7:0] = result_high_q;
      OFF_RESULT_LOW: prdata[7:0] = result_low_q;
      OFF_CHANNEL_CTRL: prdata[7:0] = chan_ctrl_q;
      OFF_REF_PIN_CFG: prdata[7:0] = ref_pin_q;
      OFF_TIMING_FMT: prdata[7:0] = timing_q;
      OFF_DIR_A: prdata[7:0] = dir_a_q;
      OFF_DIR_F: prdata[7:0] = dir_f_q;
      OFF_DIR_H: prdata[7:0] = dir_h_q;
      OFF_COMPARE2_CTRL: prdata[7:0] = cmp2_q;
      default: rd_ok = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: tb/adcsq_props.sv
// Port-level checker for the conversion sequencer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module adcsq_props
  import adcseq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_bor_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic compare2_event,
  input wire logic timer_three_selected,
  input wire logic [11:0] analog_sample,
  input wire logic [3:0] channel_select,
  input wire logic sample_hold,
  input wire logic timer_one_reset,
  input wire logic timer_three_reset,
  input wire logic irq_high,
  input wire logic irq_low
);
  logic wr;
  logic rd;
  logic ev_q;
  logic [3:0] mode_q;
  logic on_q;
  logic gie_q;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign ev_q = compare2_event && mode_q == COMPARE2_SPECIAL_EVENT;
  // Shadows of the few register bits that the port relations depend on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 4'h0;
      on_q <= 1'b0;
      gie_q <= 1'b0;
    end else begin
      if (wr && paddr == OFF_COMPARE2_CTRL) mode_q <= pwdata[3:0];
      if (wr && paddr == OFF_CHANNEL_CTRL) on_q <= pwdata[0];
      if (wr && paddr == OFF_IRQ_GLOBAL) gie_q <= pwdata[7];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (psel |-> pready) else $error("pready low");
  bad_addr_a: assert property (psel && penable && (paddr > 8'h3C || paddr[1:0] != 2'h0)
    |-> pslverr) else $error("unmapped access not refused");
  upper_zero_a: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  unimpl_ctrl_a: assert property (rd && paddr == OFF_CHANNEL_CTRL
    |-> (prdata[7:0] & ~MASK_CHANNEL_CTRL) == 8'h00) else $error("unused bits read one");
  chan_sel_a: assert property (wr && paddr == OFF_CHANNEL_CTRL
    |=> channel_select == $past(pwdata[5:2])) else $error("channel select wrong");
  timer_route_a: assert property (ev_q |-> timer_three_reset == timer_three_selected
    && timer_one_reset != timer_three_selected) else $error("timer reset misrouted");
  timer_quiet_a: assert property (!ev_q |-> !timer_one_reset && !timer_three_reset)
    else $error("stray timer reset");
  // The abort lands one edge after the converter is switched off, so allow that edge.
  conv_on_a: assert property (sample_hold |-> on_q || $past(on_q)) else $error("converting while off");
  conv_len_a: assert property ($rose(sample_hold)
    |-> sample_hold [*8] ##[12:900] !sample_hold) else $error("conversion length wrong");
  irq_gate_a: assert property (!gie_q && !$past(gie_q) |-> !irq_high && !irq_low)
    else $error("request without global enable");
  irq_excl_a: assert property (!(irq_high && irq_low)) else $error("both levels");
endmodule
bind adcsq_top adcsq_props props_i (.*);
`default_nettype wire

// file: tb/adcsq_top_test.sv
// Self-checking bench for the conversion sequencer top.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_test import adcseq_pkg::*;;
  logic pclk, presetn, por_bor_n, psel, penable, pwrite, pready, pslverr, err;
  logic compare2_event, timer_three_selected, sample_hold, timer_one_reset, timer_three_reset;
  logic irq_high, irq_low, r1, r3;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [11:0] analog_sample;
  logic [3:0] channel_select;
  int n_fail, comparisons;
  adcsq_top #(.RC_DIV(2)) uut (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Zero wait states are expected, yet the access phase still waits on pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic run(output int lat, output int len);
    lat = 0;
    len = 0;
    while (sample_hold !== 1'b1) begin
      @(posedge pclk);
      lat++;
    end
    while (sample_hold === 1'b1) begin
      @(posedge pclk);
      len++;
    end
  endtask
  task automatic pulse(input logic t3);
    @(posedge pclk);
    timer_three_selected <= t3;
    compare2_event <= 1'b1;
    @(posedge pclk);
    r1 = timer_one_reset;
    r3 = timer_three_reset;
    compare2_event <= 1'b0;
  endtask
  task automatic t_regs();
    logic [7:0] a [4] = '{OFF_FLAGS_TWO, OFF_REF_PIN_CFG, OFF_TIMING_FMT, OFF_COMPARE2_CTRL};
    logic [7:0] m [4] = '{MASK_FLAGS_TWO, MASK_REF_PIN_CFG, MASK_TIMING_FMT, MASK_COMPARE2};
    for (int i = 0; i < 4; i++) begin
      wr(a[i], 32'hFFFF_FFFF);
      rd(a[i], {24'h0, m[i]});
      wr(a[i], 32'h0);
    end
    wr(OFF_CHANNEL_CTRL, 32'hF0);
    rd(OFF_CHANNEL_CTRL, 32'h30);
    chk({28'h0, channel_select}, 32'hC);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("registers test done");
  endtask
  task automatic t_conv();
    logic [7:0] tf [4] = '{8'h80, 8'h88, 8'h15, 8'h83};
    logic [7:0] hi [4] = '{8'h0A, 8'h0A, 8'hAB, 8'h0A};
    logic [7:0] lo [4] = '{8'hBC, 8'hBC, 8'hC0, 8'hBC};
    int per [4] = '{2, 2, 16, 2};
    int lat [4];
    int len;
    analog_sample <= 12'hABC;
    wr(OFF_DIR_A, 32'hFF);
    rd(OFF_DIR_A, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_TIMING_FMT, {24'h0, tf[i]});
      wr(OFF_CHANNEL_CTRL, 32'h05);
      wr(OFF_CHANNEL_CTRL, 32'h07);
      run(lat[i], len);
      chk(32'(len >= 14 * per[i] - 2 && len <= 14 * per[i] + 2), 32'h1);
      rd(OFF_CHANNEL_CTRL, 32'h05);
      rd(OFF_FLAGS_ONE, 32'h40);
      rd(OFF_FLAGS_ONE, 32'h40);
      rd(OFF_RESULT_HIGH, {24'h0, hi[i]});
      rd(OFF_RESULT_LOW, {24'h0, lo[i]});
      wr(OFF_FLAGS_ONE, 32'h0);
      // Longer than two conversion periods of the slowest clock used here.
      repeat (40) @(posedge pclk);
    end
    chk(32'(lat[1] - lat[0] >= 3), 32'h1);
    chk(32'(lat[3] - lat[0] >= 4), 32'h1);
    $display("conversion test done");
  endtask
  task automatic t_trig();
    int l;
    int n;
    wr(OFF_COMPARE2_CTRL, 32'h0B);
    wr(OFF_CHANNEL_CTRL, 32'h00);
    pulse(1'b0);
    chk({30'h0, r1, r3}, 32'h2);
    repeat (20) @(posedge pclk);
    rd(OFF_CHANNEL_CTRL, 32'h00);
    wr(OFF_COMPARE2_CTRL, 32'h0A);
    wr(OFF_CHANNEL_CTRL, 32'h01);
    pulse(1'b1);
    chk({30'h0, r1, r3}, 32'h0);
    rd(OFF_CHANNEL_CTRL, 32'h01);
    wr(OFF_COMPARE2_CTRL, 32'h0B);
    pulse(1'b1);
    chk({30'h0, r1, r3}, 32'h1);
    rd(OFF_CHANNEL_CTRL, 32'h03);
    run(l, n);
    chk(32'(n >= 26 && n <= 30), 32'h1);
    wr(OFF_FLAGS_ONE, 32'h0);
    $display("trigger test done");
  endtask
  task automatic t_irq();
    wr(OFF_ENABLES_ONE, 32'h40);
    wr(OFF_FLAGS_ONE, 32'h40);
    repeat (2) @(posedge pclk);
    chk({30'h0, irq_high, irq_low}, 32'h0);
    wr(OFF_IRQ_GLOBAL, 32'h80);
    for (int p = 0; p < 2; p++) begin
      wr(OFF_PRIORITY_ONE, p[0] ? 32'h40 : 32'h0);
      repeat (2) @(posedge pclk);
      chk({30'h0, irq_high, irq_low}, p[0] ? 32'h2 : 32'h1);
    end
    wr(OFF_FLAGS_ONE, 32'h0);
    repeat (2) @(posedge pclk);
    chk({30'h0, irq_high, irq_low}, 32'h0);
    $display("interrupt test done");
  endtask
  task automatic t_por();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_RESULT_LOW, 32'hBC);
    rd(OFF_CHANNEL_CTRL, 32'h00);
    por_bor_n <= 1'b0;
    repeat (2) @(posedge pclk);
    por_bor_n <= 1'b1;
    rd(OFF_RESULT_LOW, 32'h00);
    $display("reset test done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The whole sequence needs under a thousand cycles, so this margin is generous.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    {presetn, por_bor_n, psel, penable, pwrite, compare2_event, timer_three_selected} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    analog_sample = 12'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_bor_n <= 1'b1;
    t_regs();
    t_conv();
    t_trig();
    t_irq();
    t_por();
    end_of_test();
  end
endmodule
`default_nettype wire
